// file: include/adc_fe_pkg.sv
package adc_fe_pkg;

  // ==========================================================
  // register selects and layout
  localparam logic [2:0]  SEL_AMP        = 3'h0;     // amplifier_setting
  localparam logic [2:0]  SEL_IA_SCALE   = 3'h1;     // phase_a_current_scale
  localparam logic [2:0]  SEL_IB_SCALE   = 3'h2;     // phase_b_current_scale
  localparam logic [2:0]  SEL_IC_SCALE   = 3'h3;     // phase_c_current_scale
  localparam logic [2:0]  SEL_IN_SCALE   = 3'h4;     // neutral_current_scale
  localparam int          PH_AMP_LSB     = 0;        // phase_current_amp_field
  localparam int          NE_AMP_LSB     = 3;        // neutral_current_amp_field
  localparam int          VO_AMP_LSB     = 6;        // voltage_amp_field
  localparam logic [15:0] AMP_RESET      = 16'h0000; // all gains 1
  localparam logic [23:0] SCALE_RESET    = 24'h000000;
  localparam logic [2:0]  AMP_CODE_MAX   = 3'h4;     // code 4 is gain 16

  // ==========================================================
  // converter timing
  localparam int          MOD_DIV        = 16;       // modulator rate divider
  localparam real         MOD_RATE_MHZ   = 1.024;    // nominal modulator rate
  localparam real         OUT_RATE_KSPS  = 8.0;      // output word rate
  localparam int          DECIM          = int'(MOD_RATE_MHZ * 1000.0 / OUT_RATE_KSPS);
  localparam int          CODE_SHIFT     = 16;       // bit-count to 24-bit scale
  localparam logic [23:0] NOMINAL_FS     = 24'h5A7540;
  localparam logic [23:0] CODE_MAX       = 24'h7FFFFF;
  localparam logic [23:0] CODE_MIN       = 24'h800000;

  // ==========================================================
  // enumerations and carriers
  typedef enum logic [1:0] {FULL_OPERATING_MODE, REDUCED_CURRENT_MONITOR_MODE,
                            LOW_POWER_THRESHOLD_MODE, SLEEP_MODE} power_mode_t;
  typedef enum logic [1:0] {WORD_8, WORD_16, WORD_32} word_size_t;
  // channel order: 0 ia, 1 ib, 2 ic, 3 in, 4 va, 5 vb, 6 vc
  typedef struct packed {
    logic [6:0][23:0] code;
  } sample_set_t;

endpackage

// file: tb/adc_front_end_tb.sv
`timescale 1ns/1ps
`default_nettype none
module adc_front_end_tb;
  import adc_fe_pkg::*;

  // ==========================================================
  // stimulus and observation signals
  logic        clk, rst_b, reg_wr, reg_rd;
  power_mode_t power_mode;                  // level, taken by the block
  logic [2:0]  reg_sel;
  word_size_t  reg_size;
  logic [31:0] reg_wdata, reg_rdata;
  logic        reg_rvalid, mod_clk_en, gain_reserved, sample_valid;
  logic [6:0]  mod_bits, adc_pwr_en;
  logic [4:0]  ph_gain, ne_gain, vo_gain;
  sample_set_t samples;
  int          num_errors, checks;
  logic [15:0] amp_m;                       // model of amplifier_setting
  logic [23:0] sc_m [4];                    // model of the four current scales

  adc_front_end dut_u (.CLK(clk), .RST_B(rst_b), .POWER_MODE(power_mode), .REG_WR(reg_wr),
    .REG_RD(reg_rd), .REG_SEL(reg_sel), .REG_SIZE(reg_size), .REG_WDATA(reg_wdata),
    .REG_RDATA(reg_rdata), .REG_RVALID(reg_rvalid), .MOD_CLK_EN(mod_clk_en), .MOD_BITS(mod_bits),
    .ADC_PWR_EN(adc_pwr_en), .PHASE_I_GAIN(ph_gain), .NEUTRAL_I_GAIN(ne_gain),
    .VOLTAGE_GAIN(vo_gain), .GAIN_RESERVED(gain_reserved), .SAMPLES(samples),
    .SAMPLE_VALID(sample_valid));

  // ==========================================================
  // clock, 8 ns period
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // ==========================================================
  // helpers: inputs always move 1 ns after the rising edge
  task automatic step();
    @(posedge clk);
    #1;
  endtask

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic test_done();
    $display("checks %0d num_errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // one write, then an idle edge so the strobe is never lowered and raised at once
  task automatic wr(input logic [2:0] sel, input word_size_t sz, input logic [31:0] d);
    reg_wr = 1'b1; reg_sel = sel; reg_size = sz; reg_wdata = d;
    step();
    reg_wr = 1'b0;
    step();
  endtask

  // read of the given width; answer must stand exactly one edge after the request
  task automatic rdchk(input logic [2:0] sel, input word_size_t sz, input logic [31:0] exp);
    reg_rd = 1'b1; reg_sel = sel; reg_size = sz;
    step();
    reg_rd = 1'b0;
    check("read valid", 32'(reg_rvalid), 32'h1);
    check("read data", reg_rdata, exp);
    step();
  endtask

  // one-hot gain expected from a field code; reserved codes fall back to gain 1
  function automatic logic [4:0] ohot(input logic [2:0] c);
    return (c <= 3'h4) ? 5'(5'h01 << c) : 5'h01;
  endfunction

  function automatic logic [6:0] pwr(input int m);
    return (m == 0) ? 7'h7F : ((m == 1) ? 7'h07 : 7'h00);
  endfunction

  // boxcar of 128 bits, clamp, then current scaling with floor shift and saturation
  function automatic logic [23:0] model(input int ones, input bit scaled, input logic [23:0] g, input bit on);
    longint x;
    longint y;
    x = longint'(2 * ones - 128) * 65536;
    if (x > 8388607) x = 8388607;
    y = scaled ? x + ((x * longint'(signed'(g))) >>> 23) : x;
    if (y > 8388607) y = 8388607;
    if (y < -8388608) y = -8388608;
    return on ? y[23:0] : 24'h000000;
  endfunction

  task automatic check_gains();
    check("phase gain", 32'(ph_gain), 32'(ohot(amp_m[2:0])));
    check("neutral gain", 32'(ne_gain), 32'(ohot(amp_m[5:3])));
    check("voltage gain", 32'(vo_gain), 32'(ohot(amp_m[8:6])));
    check("reserved flag", 32'(gain_reserved),
          32'(amp_m[2:0] > 3'h4 || amp_m[5:3] > 3'h4 || amp_m[8:6] > 3'h4));
    rdchk(SEL_AMP, WORD_32, {16'h0000, amp_m});
  endtask

  // bounded wait for the sample strobe; running out ends the run
  task automatic wait_valid(input int lim, inout int cyc);
    for (int n = 0; n < lim && sample_valid !== 1'b1; n++)
    begin
      step();
      cyc++;
    end
    if (sample_valid !== 1'b1)
    begin
      check("sample valid", 32'(sample_valid), 32'h1);
      test_done();
    end
  endtask

  // one full window of modulator bits, then compare all seven codes
  task automatic run_window(input bit all_ones, input int m);
    int ones [7];
    int cyc;
    int k;
    int last;
    logic [6:0] b;
    logic [6:0] p;
    cyc = 0; k = 0; last = 0; ones = '{default: 0};
    p = pwr(m);
    wait_valid(2100, cyc);
    cyc = 0;
    while (k < 128 && cyc < 2100)
    begin
      if (mod_clk_en === 1'b1)
      begin
        if (k > 0) check("pulse spacing", 32'(cyc - last), 32'd16);
        last = cyc;
        b = all_ones ? 7'h7F : 7'($urandom);
        mod_bits = b;
        for (int c = 0; c < 7; c++) ones[c] += int'(b[c]);
        k++;
      end
      step();
      cyc++;
    end
    wait_valid(40, cyc);
    check("window period", 32'(cyc), 32'd2048);
    for (int c = 0; c < 7; c++)
      check("sample code", 32'(samples.code[c]),
            32'(model(ones[c], c < 4, sc_m[c % 4], p[c])));
  endtask

  // ==========================================================
  // main sequence
  initial
  begin
    logic [31:0] d;
    rst_b = 1'b0; reg_wr = 1'b0; reg_rd = 1'b0; reg_sel = 3'h0; reg_size = WORD_32;
    reg_wdata = 32'h00000000; mod_bits = 7'h00; power_mode = FULL_OPERATING_MODE;
    num_errors = 0; checks = 0; amp_m = 16'h0000; sc_m = '{default: 24'h000000};
    repeat (6) @(posedge clk);
    #1 rst_b = 1'b1;
    void'($urandom(32'hA4104494));
    // reset values, then every field code including the reserved ones
    check_gains();
    for (int s = 1; s < 5; s++) rdchk(3'(s), WORD_32, 32'h00000000);
    for (int c = 0; c < 8; c++)
    begin
      d = $urandom;
      amp_m = {d[15:9], 3'(c + 2), 3'(c + 1), 3'(c)};
      wr(SEL_AMP, WORD_16, {d[31:16], amp_m});
      check_gains();
    end
    d = $urandom;
    wr(SEL_AMP, WORD_8, d);                 // narrow write touches the low byte only
    amp_m[7:0] = d[7:0];
    check_gains();
    // scales: full write, then a 16-bit write over the low half
    for (int s = 1; s < 5; s++)
    begin
      d = $urandom;
      wr(3'(s), WORD_32, d);
      sc_m[s - 1] = d[23:0];
      d = $urandom;
      wr(3'(s), WORD_16, d);
      sc_m[s - 1][15:0] = d[15:0];
      rdchk(3'(s), WORD_32, {4'h0, {4{sc_m[s - 1][23]}}, sc_m[s - 1]});
    end
    // narrow reads return only the low bytes of the port word
    rdchk(SEL_IA_SCALE, WORD_8, {24'h000000, sc_m[0][7:0]});
    rdchk(SEL_IC_SCALE, WORD_16, {16'h0000, sc_m[2][15:0]});
    for (int s = 5; s < 8; s++)
    begin
      wr(3'(s), WORD_32, $urandom);         // unmapped: nothing stored
      rdchk(3'(s), WORD_32, 32'h00000000);
    end
    for (int m = 0; m < 4; m++)
    begin
      power_mode = power_mode_t'(m);
      step();
      step();
      check("power enables", 32'(adc_pwr_en), 32'(pwr(m)));
    end
    power_mode = FULL_OPERATING_MODE;
    run_window(1'b0, 0);
    // extreme scales: +100 percent saturates, -100 percent gives zero
    wr(SEL_IA_SCALE, WORD_32, 32'h007FFFFF);
    wr(SEL_IB_SCALE, WORD_32, 32'h00800000);
    sc_m[0] = 24'h7FFFFF;
    sc_m[1] = 24'h800000;
    run_window(1'b1, 0);
    run_window(1'b0, 0);
    // zero scale on phase a must leave its code untouched
    wr(SEL_IA_SCALE, WORD_32, 32'h00000000);
    sc_m[0] = 24'h000000;
    power_mode = REDUCED_CURRENT_MONITOR_MODE;
    run_window(1'b0, 1);
    power_mode = SLEEP_MODE;
    run_window(1'b1, 3);
    test_done();
  end
endmodule
`default_nettype wire

// file: verilog/adc_front_end.sv
`timescale 1ns/1ps
`default_nettype none
module adc_front_end
  import adc_fe_pkg::*;
(
  input  wire logic        CLK,            // device input clock
  input  wire logic        RST_B,          // async reset, active low
  input  wire power_mode_t POWER_MODE,     // current power mode
  input  wire logic        REG_WR,         // register write strobe
  input  wire logic        REG_RD,         // register read strobe
  input  wire logic [2:0]  REG_SEL,        // register select
  input  wire word_size_t  REG_SIZE,       // transfer word size
  input  wire logic [31:0] REG_WDATA,      // write data, low-justified
  output logic      [31:0] REG_RDATA,      // read data
  output logic             REG_RVALID,     // read data valid pulse
  output logic             MOD_CLK_EN,     // modulator sample pulse
  input  wire logic [6:0]  MOD_BITS,       // modulator bit streams
  output logic      [6:0]  ADC_PWR_EN,     // converter power enables
  output logic      [4:0]  PHASE_I_GAIN,   // phase current amplifier gain
  output logic      [4:0]  NEUTRAL_I_GAIN, // neutral amplifier gain
  output logic      [4:0]  VOLTAGE_GAIN,   // voltage amplifier gain
  output logic             GAIN_RESERVED,  // a field holds a reserved code
  output sample_set_t      SAMPLES,        // output codes, current channels scaled
  output logic             SAMPLE_VALID    // new sample set pulse
);

  // ==========================================================
  // helpers
  // clamp a wide signed value into the 24-bit code range
  function automatic logic [23:0] sat24(input logic signed [48:0] v);
    if (v > $signed({25'h0, CODE_MAX}))
      sat24 = CODE_MAX;
    else if (v < $signed({{25{1'b1}}, CODE_MIN}))
      sat24 = CODE_MIN;
    else
      sat24 = v[23:0];
  endfunction

  // amplifier code to gain; reserved codes fall back to unity
  function automatic logic [4:0] amp_gain(input logic [2:0] c);
    amp_gain = (c <= AMP_CODE_MAX) ? 5'(5'h01 << c) : 5'h01;
  endfunction

  // x * (1 + g / 2^23), saturated
  function automatic logic [23:0] apply_scale(input logic [23:0] x, input logic [23:0] g);
    logic signed [47:0] prod;
    prod = $signed(x) * $signed(g);
    apply_scale = sat24(49'($signed(x)) + 49'(prod >>> 23));
  endfunction

  // gain register as a 32-bit port word: zero nibble, 28-bit sign extension
  function automatic logic [31:0] scale_word(input logic [23:0] g);
    scale_word = {4'h0, {4{g[23]}}, g};
  endfunction

  // ==========================================================
  // register file
  logic [15:0]       amp_q;       // amplifier_setting
  logic [3:0][23:0]  scale_q;     // current scale registers, ia ib ic in
  logic [31:0]       wmask;       // bytes covered by the transfer
  logic [31:0]       rd_word;     // selected register as port word
  logic [2:0]        sidx;        // scale register index

  // narrower transfers touch only the low bytes of a register
  assign wmask = (REG_SIZE == WORD_8)  ? 32'h000000FF :
                 (REG_SIZE == WORD_16) ? 32'h0000FFFF : 32'hFFFFFFFF;
  assign sidx  = REG_SEL - SEL_IA_SCALE;
  assign rd_word = (REG_SEL == SEL_AMP) ? {16'h0000, amp_q} :
                   (REG_SEL >= SEL_IA_SCALE && REG_SEL <= SEL_IN_SCALE) ?
                   scale_word(scale_q[sidx[1:0]]) : 32'h00000000;

  // writes; unmapped selects are ignored
  always_ff @(posedge CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      amp_q   <= AMP_RESET;
      scale_q <= {4{SCALE_RESET}};
    end
    else if (REG_WR)
    begin
      if (REG_SEL == SEL_AMP)
        amp_q <= (amp_q & ~wmask[15:0]) | (REG_WDATA[15:0] & wmask[15:0]);
      else if (REG_SEL >= SEL_IA_SCALE && REG_SEL <= SEL_IN_SCALE)
        scale_q[sidx[1:0]] <= (scale_q[sidx[1:0]] & ~wmask[23:0]) | (REG_WDATA[23:0] & wmask[23:0]);
    end
  end

  // reads answer one cycle after the strobe, cut to the word size
  always_ff @(posedge CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      REG_RDATA  <= 32'h00000000;
      REG_RVALID <= 1'b0;
    end
    else
    begin
      REG_RVALID <= REG_RD;
      if (REG_RD)
        REG_RDATA <= rd_word & wmask;
    end
  end

  // ==========================================================
  // amplifier gain selection
  logic [2:0] ph_code;  // phase current field
  logic [2:0] ne_code;  // neutral field
  logic [2:0] vo_code;  // voltage field

  assign ph_code = amp_q[PH_AMP_LSB +: 3];
  assign ne_code = amp_q[NE_AMP_LSB +: 3];
  assign vo_code = amp_q[VO_AMP_LSB +: 3];

  // gains registered so the analog side sees clean levels
  always_ff @(posedge CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      PHASE_I_GAIN   <= 5'h01;
      NEUTRAL_I_GAIN <= 5'h01;
      VOLTAGE_GAIN   <= 5'h01;
      GAIN_RESERVED  <= 1'b0;
    end
    else
    begin
      PHASE_I_GAIN   <= amp_gain(ph_code);
      NEUTRAL_I_GAIN <= amp_gain(ne_code);
      VOLTAGE_GAIN   <= amp_gain(vo_code);
      GAIN_RESERVED  <= (ph_code > AMP_CODE_MAX) || (ne_code > AMP_CODE_MAX) ||
                        (vo_code > AMP_CODE_MAX);
    end
  end

  // ==========================================================
  // power gating per mode
  logic [6:0] pwr_d;  // enables implied by the mode

  assign pwr_d = (POWER_MODE == FULL_OPERATING_MODE)          ? 7'h7F :
                 (POWER_MODE == REDUCED_CURRENT_MONITOR_MODE) ? 7'h07 :
                                                                7'h00;

  always_ff @(posedge CLK or negedge RST_B)
  begin
    if (!RST_B)
      ADC_PWR_EN <= 7'h00;
    else
      ADC_PWR_EN <= pwr_d;
  end

  // ==========================================================
  // modulator rate divider and decimation window
  logic [3:0] div_q;  // input clock divider
  logic [6:0] dec_q;  // modulator samples in the current window
  logic       win_end;

  assign MOD_CLK_EN = (div_q == 4'(MOD_DIV - 1));
  assign win_end    = MOD_CLK_EN && (dec_q == 7'(DECIM - 1));

  always_ff @(posedge CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      div_q <= 4'h0;
      dec_q <= 7'h00;
    end
    else
    begin
      div_q <= div_q + 4'h1;  // wraps every sixteen clocks
      if (MOD_CLK_EN)
        dec_q <= dec_q + 7'h01;
    end
  end

  // ==========================================================
  // decimating filter: a 128-tap boxcar; every channel uses the same
  // arithmetic so equal inputs give equal codes, at the cost of a
  // poorer stopband than a real sinc cascade
  logic [6:0][7:0]  ones_q;  // ones counted per channel
  logic [6:0][23:0] raw;     // unscaled code at window end
  logic [6:0][7:0]  ones_n;  // count including this bit

  for (genvar c = 0; c < 7; c++)
  begin : g_ch
    logic signed [10:0] bal;  // ones minus zeros
    assign ones_n[c] = ones_q[c] + {7'h00, MOD_BITS[c]};
    assign bal       = $signed({2'b00, ones_n[c], 1'b0}) - 11'sd128;
    assign raw[c]    = sat24(49'(bal) <<< CODE_SHIFT);
  end

  // count ones; unpowered channels stay cleared
  always_ff @(posedge CLK or negedge RST_B)
  begin
    if (!RST_B)
      ones_q <= '0;
    else if (MOD_CLK_EN)
    begin
      for (int c = 0; c < 7; c++)
        ones_q[c] <= (win_end || !ADC_PWR_EN[c]) ? 8'h00 : ones_n[c];
    end
  end

  // ==========================================================
  // current scaling and output words; the live scale register is
  // used, so a new value reaches its own channel's code from the next word on
  always_ff @(posedge CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      SAMPLES      <= '0;
      SAMPLE_VALID <= 1'b0;
    end
    else
    begin
      SAMPLE_VALID <= win_end;
      if (win_end)
      begin
        for (int c = 0; c < 7; c++)
        begin
          if (!ADC_PWR_EN[c])
            SAMPLES.code[c] <= 24'h000000;
          else if (c < 4)
            SAMPLES.code[c] <= apply_scale(raw[c], scale_q[2'(c)]);
          else
            SAMPLES.code[c] <= raw[c];
        end
      end
    end
  end

  // ==========================================================
  // checks
  logic [7:0] gap_q;  // clocks since last modulator pulse
  always_ff @(posedge CLK or negedge RST_B)
  begin
    if (!RST_B)
      gap_q <= 8'h00;
    else
      gap_q <= MOD_CLK_EN ? 8'h00 : gap_q + 8'h01;
  end

  // clocks since the last output word; a counter stands in for a long
  // delay, which the property tools would have to unroll
  logic [11:0] word_gap_q;   // clocks since SAMPLE_VALID
  logic        word_seen_q;  // one word seen since reset
  always_ff @(posedge CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      word_gap_q  <= 12'h000;
      word_seen_q <= 1'b0;
    end
    else
    begin
      word_gap_q  <= SAMPLE_VALID ? 12'h000 : word_gap_q + 12'h001;
      word_seen_q <= word_seen_q || SAMPLE_VALID;
    end
  end

  AST_DIV16: assert property (@(posedge CLK) disable iff (!RST_B)
    MOD_CLK_EN |-> ##1 !MOD_CLK_EN [*8] ##1 !MOD_CLK_EN [*7] ##1 MOD_CLK_EN)
    else $error("modulator pulse not every sixteen clocks");
  AST_GAP: assert property (@(posedge CLK) disable iff (!RST_B)
    gap_q <= 8'd15)
    else $error("modulator pulse missing");
  AST_PH_GAIN: assert property (@(posedge CLK) disable iff (!RST_B)
    ##1 (PHASE_I_GAIN == amp_gain($past(amp_q[2:0]))))
    else $error("phase gain does not follow low field");
  AST_NE_GAIN: assert property (@(posedge CLK) disable iff (!RST_B)
    $changed(amp_q[5:3]) && amp_q[5:3] == 3'h2 |=> NEUTRAL_I_GAIN == 5'h04)
    else $error("neutral gain wrong");
  AST_VO_GAIN: assert property (@(posedge CLK) disable iff (!RST_B)
    amp_q[8:6] == 3'h4 |=> VOLTAGE_GAIN == 5'h10)
    else $error("voltage gain wrong");
  AST_GAIN_SET: assert property (@(posedge CLK) disable iff (!RST_B)
    $onehot(PHASE_I_GAIN) && $onehot(NEUTRAL_I_GAIN) && $onehot(VOLTAGE_GAIN))
    else $error("gain outside allowed set");
  AST_RESERVED: assert property (@(posedge CLK) disable iff (!RST_B)
    amp_q[2:0] > 3'h4 |=> GAIN_RESERVED && PHASE_I_GAIN == 5'h01)
    else $error("reserved code not flagged");
  AST_FULL: assert property (@(posedge CLK) disable iff (!RST_B)
    POWER_MODE == FULL_OPERATING_MODE |=> ADC_PWR_EN == 7'h7F)
    else $error("full mode not all powered");
  AST_REDUCED: assert property (@(posedge CLK) disable iff (!RST_B)
    POWER_MODE == REDUCED_CURRENT_MONITOR_MODE |=> ADC_PWR_EN == 7'h07)
    else $error("reduced mode power wrong");
  AST_OFF: assert property (@(posedge CLK) disable iff (!RST_B)
    (POWER_MODE == LOW_POWER_THRESHOLD_MODE || POWER_MODE == SLEEP_MODE) |=> ADC_PWR_EN == 7'h00)
    else $error("converters not powered down");
  AST_RATE: assert property (@(posedge CLK) disable iff (!RST_B)
    SAMPLE_VALID && word_seen_q |-> word_gap_q == 12'(DECIM * MOD_DIV - 1))
    else $error("output word rate wrong");
  AST_RATE_GAP: assert property (@(posedge CLK) disable iff (!RST_B)
    word_seen_q |-> word_gap_q <= 12'(DECIM * MOD_DIV - 1))
    else $error("output word missing");
  AST_GATED: assert property (@(posedge CLK) disable iff (!RST_B)
    SAMPLE_VALID && $past(ADC_PWR_EN[6:4]) == 3'h0 |-> SAMPLES.code[6:4] == '0)
    else $error("powered-down channel gave data");
  AST_UNITY: assert property (@(posedge CLK) disable iff (!RST_B)
    win_end && ADC_PWR_EN[0] && scale_q[0] == 24'h0 |=> SAMPLES.code[0] == $past(raw[0]))
    else $error("zero scale altered phase a");
  AST_READ: assert property (@(posedge CLK) disable iff (!RST_B)
    REG_RD && REG_SEL == SEL_IA_SCALE && REG_SIZE == WORD_32 |=>
    REG_RVALID && REG_RDATA == {4'h0, {4{$past(scale_q[0][23])}}, $past(scale_q[0])})
    else $error("scale read format wrong");
  AST_NARROW: assert property (@(posedge CLK) disable iff (!RST_B)
    REG_RD && REG_SIZE == WORD_8 |=> REG_RDATA[31:8] == 24'h0)
    else $error("byte read not masked");

endmodule
`default_nettype wire
